// *** ums_fifo.sv ***
`timescale 1ns/1ps
module ums_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count_q != FULL_CNT);
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_q <= count_q + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// *** ums_master.sv ***
// Function
// RL1 - Twelve bit baud divider, high and low bytes.
// RL2 - Polarity and phase select SPI modes 0-3.
// RL3 - Shift and sample on opposite clock edges.
// RL4 - Software keeps format bits stable during transfers.
// RL5 - Frame is exactly eight data bits.
// RL6 - One bit order setting for both directions.
// RL7 - Next frame follows at once, else output high.
// RL8 - Two bytes sent, complete after the second.
// RL9 - Software sets divider, pin, format, enables first.
// RL10 - Transmitter runs alone; receiver needs the transmitter.
// RL11 - Software holds divider zero while enabling transmitter.
// RL12 - Baud divider resets to zero.
// RL13 - Software clears complete flag before each write.
// RL14 - Transmitter enable required, owns serial output.
// RL15 - Receiver enable optional, owns serial input.
// RL16 - Data write starts a send and receive transfer.
// RL17 - Buffer enters shifter only when shifter free.
// RL18 - Software reads one byte per byte sent.
// RL19 - Overflow keeps older bytes, third of four lost.
// RL20 - Clock rate is system clock over 2(div+1).
// RL21 - Master SPI only when mode select is 11.
// RL22 - Transmit buffer empty flag set after reset.
// RL23 - Framing, overrun, parity flags always read zero.
// RL24 - Idle serial clock rests at polarity level.
`timescale 1ns/1ps
module ums_master #(
  parameter int TX_DEPTH = 4,
  parameter int RX_DEPTH = 2
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [1:0] PORT_MODE_SELECT,
  input ums_pkg::ums_cfg_t CFG,
  input wire logic TRANSMITTER_ENABLE_BIT,
  input wire logic RECEIVER_ENABLE_BIT,
  input wire logic CLOCK_PIN_DIRECTION_BIT,
  input wire logic [7:0] BAUD_WDATA,
  input wire logic BAUD_WR_HIGH,
  input wire logic BAUD_WR_LOW,
  input wire logic DATA_WR,
  input wire logic [7:0] DATA_WDATA,
  input wire logic DATA_RD,
  input wire logic TXC_CLEAR,
  output logic [7:0] DATA_RDATA,
  output logic [11:0] BAUD_DIVIDER,
  output logic TX_BUFFER_EMPTY_FLAG,
  output logic TRANSMIT_COMPLETE_FLAG,
  output logic RECEIVE_COMPLETE_FLAG,
  output logic FRAMING_ERROR_FLAG,
  output logic OVERRUN_FLAG,
  output logic PARITY_ERROR_FLAG,
  output logic SERIAL_CLOCK_PIN_O,
  output logic SERIAL_CLOCK_PIN_OE,
  output logic SERIAL_OUT_PIN_O,
  output logic SERIAL_OUT_PIN_OE,
  input wire logic SERIAL_IN_PIN,
  output logic SERIAL_IN_PIN_OWNED
);
  import ums_pkg::*;

  logic [BAUD_W-1:0] baud_q;
  ums_state_t state_q;
  logic [4:0] edge_q;
  logic sck_q;
  logic [DATA_W-1:0] tx_sh_q;
  logic [DATA_W-1:0] rx_sh_q;
  logic txc_q;
  logic sdi_s1_q;
  logic sdi_s2_q;
  logic sdi_s3_q;
  logic sdi_q;
  logic hold_valid_q;
  logic [DATA_W-1:0] hold_q;

  logic mode_ok;
  logic tick;
  logic tx_valid;
  logic [DATA_W-1:0] tx_data;
  logic load;
  logic sample_edge;
  logic shift_edge;
  logic frame_done;
  logic done_rx;
  logic [DATA_W-1:0] rx_next;
  logic rx_in_valid;
  logic rx_in_ready;
  logic [DATA_W-1:0] rx_in_data;
  logic rx_flush;

  assign mode_ok = (PORT_MODE_SELECT == MODE_MASTER_SPI); // [RL21]

  // Divider bytes are written separately, a high write winning in the same cycle;
  // only bits 3:0 of the high byte are kept, as divider bits 11:8.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      baud_q <= BAUD_RESET; // [RL12]
    end else if (BAUD_WR_HIGH) begin
      baud_q[11:8] <= BAUD_WDATA[3:0]; // [RL1]
    end else if (BAUD_WR_LOW) begin
      baud_q[7:0] <= BAUD_WDATA; // [RL1]
    end
  end
  assign BAUD_DIVIDER = baud_q;

  ums_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(TX_DEPTH)
  ) u_tx_fifo (
    .clk(CLK),
    .rst_n(RESET_N),
    .flush(1'b0),
    .in_valid(DATA_WR),
    .in_ready(TX_BUFFER_EMPTY_FLAG), // [RL22]
    .in_data(DATA_WDATA),
    .out_valid(tx_valid),
    .out_ready(load),
    .out_data(tx_data)
  );

  // The half-period tick runs only inside a frame, which gives the
  // fOSC / 2(div+1) serial clock rate.
  ums_tick #(
    .DIV_W(BAUD_W)
  ) u_tick (
    .clk(CLK),
    .rst_n(RESET_N),
    .run(state_q == ST_SHIFT),
    .div(baud_q),
    .tick(tick)
  ); // [RL20]

  // Even edges are leading edges; phase picks which set samples.
  assign sample_edge = tick && (edge_q[0] == CFG.clock_phase_bit); // [RL2]
  assign shift_edge = tick && (edge_q[0] != CFG.clock_phase_bit) &&
                      (edge_q != '0); // [RL3]
  assign frame_done = tick && (edge_q == LAST_EDGE); // [RL5]
  assign load = tx_valid && mode_ok && TRANSMITTER_ENABLE_BIT &&
                ((state_q == ST_IDLE) || frame_done); // [RL16] [RL17]

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_q <= ST_IDLE;
      edge_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          edge_q <= '0;
          if (load) begin
            state_q <= ST_SHIFT; // [RL14]
          end
        end
        ST_SHIFT: begin
          if (frame_done) begin
            edge_q <= '0;
            state_q <= load ? ST_SHIFT : ST_IDLE; // [RL7]
          end else if (tick) begin
            edge_q <= edge_q + 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          edge_q <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sck_q <= 1'b0;
    end else if (state_q == ST_IDLE || frame_done) begin
      sck_q <= 1'b0;
    end else if (tick) begin
      sck_q <= ~sck_q;
    end
  end
  assign SERIAL_CLOCK_PIN_O = sck_q ^ CFG.clock_polarity_bit; // [RL24]
  assign SERIAL_CLOCK_PIN_OE = CLOCK_PIN_DIRECTION_BIT;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      tx_sh_q <= DATA_RESET;
    end else if (load) begin
      tx_sh_q <= tx_data;
    end else if (shift_edge) begin
      tx_sh_q <= CFG.bit_order_bit ? {1'b1, tx_sh_q[7:1]} :
                 {tx_sh_q[6:0], 1'b1}; // [RL6]
    end
  end

  always_comb begin
    if (state_q == ST_SHIFT) begin
      SERIAL_OUT_PIN_O = CFG.bit_order_bit ? tx_sh_q[0] : tx_sh_q[7];
    end else begin
      SERIAL_OUT_PIN_O = SDO_IDLE; // [RL7]
    end
  end
  // Releasing the pin waits for pending data, so a late disable never
  // truncates the frame in the shifter; a queued byte is not loaded until the enable returns.
  assign SERIAL_OUT_PIN_OE = TRANSMITTER_ENABLE_BIT ||
                             (state_q == ST_SHIFT) || tx_valid; // [RL14]

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
      sdi_s3_q <= 1'b0;
      sdi_q <= 1'b0;
    end else begin
      sdi_s1_q <= SERIAL_IN_PIN;
      sdi_s2_q <= sdi_s1_q;
      sdi_s3_q <= sdi_s2_q;
      if (sdi_s2_q == sdi_s3_q) begin
        sdi_q <= sdi_s3_q;
      end
    end
  end
  assign SERIAL_IN_PIN_OWNED = RECEIVER_ENABLE_BIT; // [RL15]

  always_comb begin
    if (CFG.bit_order_bit) begin
      rx_next = {sdi_q, rx_sh_q[7:1]}; // [RL6]
    end else begin
      rx_next = {rx_sh_q[6:0], sdi_q};
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rx_sh_q <= DATA_RESET;
    end else if (sample_edge) begin
      rx_sh_q <= rx_next; // [RL3]
    end
  end

  // With phase 1 the last sample lands on the final edge itself.
  assign done_rx = frame_done && RECEIVER_ENABLE_BIT; // [RL10]
  assign rx_flush = !RECEIVER_ENABLE_BIT;

  // A byte that finds the buffer full waits in the hold register, and a
  // later arrival overwrites it: the older buffered bytes survive.
  always_ff @(posedge CLK) begin
    if (!RESET_N || rx_flush) begin
      hold_valid_q <= 1'b0;
      hold_q <= DATA_RESET;
    end else if (done_rx) begin
      if (hold_valid_q || !rx_in_ready) begin
        hold_valid_q <= 1'b1;
        hold_q <= CFG.clock_phase_bit ? rx_next : rx_sh_q; // [RL19]
      end
    end else if (hold_valid_q && rx_in_ready) begin
      hold_valid_q <= 1'b0;
    end
  end

  always_comb begin
    if (hold_valid_q) begin
      rx_in_valid = !done_rx;
      rx_in_data = hold_q;
    end else begin
      rx_in_valid = done_rx;
      rx_in_data = CFG.clock_phase_bit ? rx_next : rx_sh_q;
    end
  end

  ums_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .clk(CLK),
    .rst_n(RESET_N),
    .flush(rx_flush),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_data(rx_in_data),
    .out_valid(RECEIVE_COMPLETE_FLAG),
    .out_ready(DATA_RD),
    .out_data(DATA_RDATA)
  );

  // Completion only when nothing follows, so a byte pair reports once.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      txc_q <= 1'b0;
    end else if (frame_done && !load) begin
      txc_q <= 1'b1; // [RL8]
    end else if (TXC_CLEAR) begin
      txc_q <= 1'b0;
    end
  end
  assign TRANSMIT_COMPLETE_FLAG = txc_q;

  assign FRAMING_ERROR_FLAG = 1'b0; // [RL23]
  assign OVERRUN_FLAG = 1'b0; // [RL23]
  assign PARITY_ERROR_FLAG = 1'b0; // [RL23]
endmodule

// *** ums_master_props.sv ***
`timescale 1ns/1ps
module ums_master_props (
  input wire logic CLK,
  input wire logic RESET_N,
  input ums_pkg::ums_cfg_t CFG,
  input wire logic TRANSMITTER_ENABLE_BIT,
  input wire logic RECEIVER_ENABLE_BIT,
  input wire logic CLOCK_PIN_DIRECTION_BIT,
  input wire logic [7:0] BAUD_WDATA,
  input wire logic BAUD_WR_HIGH,
  input wire logic BAUD_WR_LOW,
  input wire logic [11:0] BAUD_DIVIDER,
  input wire logic TX_BUFFER_EMPTY_FLAG,
  input wire logic TRANSMIT_COMPLETE_FLAG,
  input wire logic RECEIVE_COMPLETE_FLAG,
  input wire logic FRAMING_ERROR_FLAG,
  input wire logic OVERRUN_FLAG,
  input wire logic PARITY_ERROR_FLAG,
  input wire logic SERIAL_CLOCK_PIN_O,
  input wire logic SERIAL_CLOCK_PIN_OE,
  input wire logic SERIAL_OUT_PIN_O,
  input wire logic SERIAL_OUT_PIN_OE,
  input wire logic SERIAL_IN_PIN_OWNED
);
  import ums_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_err_zero: assert property (
    !(FRAMING_ERROR_FLAG | OVERRUN_FLAG | PARITY_ERROR_FLAG))
    else $error("error flag set");
  // Reset values are checked the cycle after reset is sampled, even once it is released.
  a_reset_vals: assert property (disable iff (1'b0)
    !RESET_N |=> BAUD_DIVIDER == BAUD_RESET && TX_BUFFER_EMPTY_FLAG)
    else $error("bad reset values");
  a_baud_high: assert property (
    BAUD_WR_HIGH |=> BAUD_DIVIDER[11:8] == $past(BAUD_WDATA[3:0]))
    else $error("baud high byte lost");
  a_baud_low: assert property (
    BAUD_WR_LOW && !BAUD_WR_HIGH |=> BAUD_DIVIDER[7:0] == $past(BAUD_WDATA))
    else $error("baud low byte lost");
  a_tx_owns: assert property (
    TRANSMITTER_ENABLE_BIT |-> SERIAL_OUT_PIN_OE)
    else $error("serial out not driven");
  a_rx_owns: assert property (
    SERIAL_IN_PIN_OWNED == RECEIVER_ENABLE_BIT)
    else $error("serial in ownership wrong");
  a_sck_dir: assert property (
    SERIAL_CLOCK_PIN_OE == CLOCK_PIN_DIRECTION_BIT)
    else $error("clock pin direction wrong");
  a_rx_flush: assert property (
    !RECEIVER_ENABLE_BIT ##1 !RECEIVER_ENABLE_BIT |-> !RECEIVE_COMPLETE_FLAG)
    else $error("receive data while disabled");
  a_idle_lines: assert property (
    $rose(TRANSMIT_COMPLETE_FLAG) |-> SERIAL_OUT_PIN_O &&
    SERIAL_CLOCK_PIN_O == CFG.clock_polarity_bit)
    else $error("lines not idle after frame");
endmodule

// *** ums_pkg.sv ***
package ums_pkg;
  localparam int DATA_W = 8;
  localparam int BAUD_W = 12;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 12'h000;
  localparam logic [1:0] MODE_MASTER_SPI = 2'h3;
  localparam logic [4:0] FRAME_EDGES = 5'h10;
  localparam logic [4:0] LAST_EDGE = 5'h0F;
  localparam int TX_DEPTH = 4;
  localparam int RX_DEPTH = 2;
  localparam logic SDO_IDLE = 1'h1;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  typedef struct packed {
    logic bit_order_bit;
    logic clock_phase_bit;
    logic clock_polarity_bit;
  } ums_cfg_t;

  typedef enum logic {ST_IDLE, ST_SHIFT} ums_state_t;
endpackage

// *** ums_slave_model.sv ***
`timescale 1ns/1ps
module ums_slave_model (
  input wire logic clk,
  input wire logic sck,
  input wire logic mosi,
  input ums_pkg::ums_cfg_t cfg,
  output logic miso,
  output logic [7:0] got,
  output logic got_v
);
  import ums_pkg::*;
  logic ph_q;
  logic [2:0] k;
  logic [2:0] ix;
  logic [7:0] sh;
  logic [7:0] t;
  logic [7:0] n;
  logic [7:0] ans;
  logic mosi_q;
  initial begin
    ph_q = 1'b0;
    k = 3'h0;
    n = 8'h00;
    got_v = 1'b0;
  end
  // Each frame answers with a byte that the bench can predict.
  assign ix = cfg.bit_order_bit ? k : 3'h7 - k;
  assign ans = 8'h5A + n;
  assign miso = ans[ix];
  always @(posedge clk) begin
    got_v <= 1'b0;
    ph_q <= sck ^ cfg.clock_polarity_bit;
    // The edge is seen one clock late, so the data bit is taken as it stood
    // before the edge; the master may move its output on that very edge.
    mosi_q <= mosi;
    // Phase is judged after polarity, so a polarity change between frames
    // is not mistaken for an edge.
    if ((sck ^ cfg.clock_polarity_bit) != ph_q &&
        ph_q == cfg.clock_phase_bit) begin
      t = sh;
      t[ix] = mosi_q;
      sh <= t;
      k <= k + 3'h1;
      if (k == 3'h7) begin
        got <= t;
        got_v <= 1'b1;
        n <= n + 8'h01;
      end
    end
  end
endmodule

// *** ums_tick.sv ***
`timescale 1ns/1ps
module ums_tick #(
  parameter int DIV_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [DIV_W-1:0] div,
  output logic tick
);
  logic [DIV_W-1:0] cnt_q;

  // Held at the divider while stopped, so every frame starts a full
  // half period after the load and a zero divider ticks every cycle.
  assign tick = run && (cnt_q == '0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (!run || cnt_q == '0) begin
      cnt_q <= div;
    end else begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// *** usart_master_spi_mode_tb_top.sv ***
`timescale 1ns/1ps
module usart_master_spi_mode_tb_top;
  import ums_pkg::*;
  localparam int DIV = 4;
  logic clk, rst_n, txen, rxen, bwh, bwl, dwr, drd, txcc;
  logic txe, txc, rxc, sck, sdo, miso, got_v, ph_q, dir;
  logic [1:0] mode;
  logic [7:0] bwd, dwd, rdat, got;
  logic [11:0] baud;
  ums_cfg_t cfg;
  logic [7:0] qtx[$], qrx[$];
  int err_total, compares, nf, nrx, n0, i, gap;
  wire ph = sck ^ cfg.clock_polarity_bit;
  ums_master dut (.CLK(clk), .RESET_N(rst_n), .PORT_MODE_SELECT(mode),
    .CFG(cfg), .TRANSMITTER_ENABLE_BIT(txen), .RECEIVER_ENABLE_BIT(rxen),
    .CLOCK_PIN_DIRECTION_BIT(dir), .BAUD_WDATA(bwd), .BAUD_WR_HIGH(bwh),
    .BAUD_WR_LOW(bwl), .DATA_WR(dwr), .DATA_WDATA(dwd), .DATA_RD(drd),
    .TXC_CLEAR(txcc), .DATA_RDATA(rdat), .BAUD_DIVIDER(baud),
    .TX_BUFFER_EMPTY_FLAG(txe), .TRANSMIT_COMPLETE_FLAG(txc),
    .RECEIVE_COMPLETE_FLAG(rxc), .FRAMING_ERROR_FLAG(), .OVERRUN_FLAG(),
    .PARITY_ERROR_FLAG(), .SERIAL_CLOCK_PIN_O(sck), .SERIAL_CLOCK_PIN_OE(),
    .SERIAL_OUT_PIN_O(sdo), .SERIAL_OUT_PIN_OE(), .SERIAL_IN_PIN(miso),
    .SERIAL_IN_PIN_OWNED());
  ums_slave_model peer (.clk(clk), .sck(sck), .mosi(sdo), .cfg(cfg),
    .miso(miso), .got(got), .got_v(got_v));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [11:0] a, input logic [11:0] e);
    compares++;
    if (a !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, a, e);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Leaves the strobe high so that writes can follow back to back.
  task automatic put(input logic [7:0] b, input bit keep);
    dwr = 1'b1;
    dwd = b;
    qtx.push_back(b);
    if (keep) qrx.push_back(8'h5A + nf[7:0]);
    nf++;
    tick(1);
  endtask
  task automatic wtxc();
    for (int j = 0; j < 2000 && txc !== 1'b1; j++) tick(1);
    chk({11'h0, txc}, 12'h001);
  endtask
  task automatic rd();
    drd = 1'b1;
    tick(1);
    drd = 1'b0;
    tick(1);
  endtask
  task automatic clr();
    txcc = 1'b1;
    tick(1);
    txcc = 1'b0;
  endtask
  always @(posedge clk) begin
    if (got_v === 1'b1) begin
      nrx++;
      if (qtx.size() > 0) chk({4'h0, got}, {4'h0, qtx.pop_front()});
      else chk({4'h0, got}, 12'hFFF);
    end
    if (rst_n && drd && rxc === 1'b1) begin
      if (qrx.size() > 0) chk({4'h0, rdat}, {4'h0, qrx.pop_front()});
      else chk({4'h0, rdat}, 12'hFFF);
    end
  end
  // Sampled on the clock, so a polarity change that reaches the clock pin
  // and this bench in different deltas is never taken for an edge.
  always @(posedge clk) begin
    ph_q <= ph;
    gap <= (ph !== ph_q) ? 1 : gap + 1;
    if (rst_n && ph !== ph_q && gap < 2 * (DIV + 1))
      chk(12'(gap), 12'(DIV + 1));
  end
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  initial begin
    {rst_n, txen, rxen, bwh, bwl, dwr, drd, txcc} = 8'h00;
    mode = 2'h3;
    dir = 1'b0;
    cfg = '0;
    bwd = 8'h00;
    dwd = 8'h00;
    void'($urandom(32'h8dd8));
    tick(3);
    rst_n = 1'b1;
    dir = 1'b1;
    txen = 1'b1;
    rxen = 1'b1;
    tick(1);
    bwh = 1'b1;
    tick(1);
    bwh = 1'b0;
    bwd = 8'(DIV);
    bwl = 1'b1;
    tick(1);
    bwl = 1'b0;
    chk(baud, 12'(DIV));
    for (i = 0; i < 8; i++) begin
      cfg = ums_cfg_t'(i[2:0]);
      clr();
      put(8'($urandom), 1'b1);
      dwr = 1'b0;
      wtxc();
      rd();
    end
    $display("modes and orders done");
    clr();
    n0 = nrx;
    put(8'($urandom), 1'b1);
    put(8'($urandom), 1'b1);
    dwr = 1'b0;
    for (int j = 0; j < 400 && nrx == n0; j++) tick(1);
    chk({11'h0, txc}, 12'h000);
    wtxc();
    rd();
    rd();
    $display("back to back done");
    txen = 1'b0;
    clr();
    n0 = nrx;
    put(8'($urandom), 1'b1);
    put(8'($urandom), 1'b1);
    put(8'($urandom), 1'b0);
    put(8'($urandom), 1'b1);
    dwd = 8'hFF;
    tick(1);
    dwr = 1'b0;
    chk({11'h0, txe}, 12'h000);
    tick(40);
    chk(12'(nrx - n0), 12'h000);
    mode = 2'h1;
    txen = 1'b1;
    tick(40);
    chk(12'(nrx - n0), 12'h000);
    mode = 2'h3;
    wtxc();
    // The partner reports its last byte a couple of cycles after the flag.
    tick(3);
    chk(12'(nrx - n0), 12'h004);
    rd();
    rd();
    rd();
    chk({11'h0, rxc}, 12'h000);
    $display("queue and overflow done");
    rxen = 1'b0;
    clr();
    put(8'($urandom), 1'b0);
    dwr = 1'b0;
    wtxc();
    chk({11'h0, rxc}, 12'h000);
    $display("transmit only done");
    wrap_up();
  end
endmodule
bind ums_master ums_master_props props_u (.*);
